// [smf_cfg.svh]
// constants for the secure memory serial front end
`ifndef SMF_CFG_SVH
`define SMF_CFG_SVH
`define SMF_CLK_MHZ 200
`define SMF_T_WR_MS 5
`define SMF_WR_CYCLES (`SMF_T_WR_MS * `SMF_CLK_MHZ * 1000)
`define SMF_ETU_CLKS 372
`define SMF_ETU_W 9
`define SMF_CHAR_LAST 4'hb
`define SMF_ATR_LAST 3'h7
`define SMF_ATR_RESET 64'h8877665544332211
`define SMF_PAGE_BYTES 16
`define SMF_MEM_BYTES 256
`define SMF_ID_NONE 4'hf
`define SMF_DEV_ATR_BIT 1
`define SMF_DEV_RW_BIT 0
`define SMF_ACK_SLOT 4'h8
`define SMF_LAST_BIT 4'h7
`define SMF_UNREADABLE 8'hff
`endif

// [smf_front_end.sv]
// serial front end: two-wire slave, answer-to-reset sender, user memory
`timescale 1ns/100ps
`include "smf_cfg.svh"

module smf_front_end
#(
  parameter int WR_CYCLES = `SMF_WR_CYCLES
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic serial_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic rst_pad,
  input wire logic rst_pad_driven,
  input wire logic [3:0] dev_id_strap,
  input wire logic t0_strap,
  input wire smf_pkg::smf_rights_t zone_rights,
  output logic prog_busy,
  output logic atr_active
);
  import smf_pkg::*;

  // zone of an address picks one access bit
  function automatic logic zone_ok(input logic [3:0] rights, input logic [7:0] a);
    zone_ok = rights[a[7:6]];
  endfunction

  // one character: start, data lsb first, even parity, guard
  function automatic logic [11:0] mk_frame(input logic [7:0] d);
    mk_frame = {2'b11, ^d, d, 1'b0};
  endfunction

  smf_pins_t pin_raw;
  smf_pins_t pin_s1;
  smf_pins_t pin_s2;
  smf_pins_t pin_q;
  logic [1:0] settle;
  logic [3:0] dev_id;
  logic t0_en;
  smf_twi_t state;
  logic [3:0] bitcnt;
  logic [6:0] shreg;
  logic [7:0] addr;
  logic atr_sel;
  logic ack_ok;
  logic [7:0] rdata;
  logic twi_low;
  logic [7:0] pg [`SMF_PAGE_BYTES];
  logic [15:0] pg_valid;
  logic [3:0] pg_page;
  logic pg_atr;
  logic [19:0] prog_cnt;
  logic [3:0] walk;
  logic [7:0] mem [`SMF_MEM_BYTES];
  logic [63:0] atr_reg;
  logic [63:0] atr_hold;
  logic atr_tgl;
  logic sync_mode;

  // pull-up: an undriven reset pad reads inactive high
  assign pin_raw.rst = rst_pad_driven ? rst_pad : 1'b1;
  assign pin_raw.sda = sda_in;
  assign pin_raw.scl = serial_clk;
  assign pin_raw.dev_id = dev_id_strap;
  assign pin_raw.t0_en = t0_strap;

  // two-flop synchronisers plus a history stage for edges
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      pin_s1 <= '1;
      pin_s2 <= '1;
      pin_q <= '1;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_q <= pin_s2;
    end
  end

  // straps are caught once the synchronisers hold real pin values
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      settle <= 2'h0;
      dev_id <= `SMF_ID_NONE;
      t0_en <= 1'b0;
    end
    else if (settle != 2'h3)
    begin
      settle <= settle + 2'h1;
      dev_id <= pin_s2.dev_id;
      t0_en <= pin_s2.t0_en;
    end
  end

  // pin events; data edges while clock high frame a command
  wire scl_rise = pin_s2.scl & ~pin_q.scl;
  wire scl_fall = ~pin_s2.scl & pin_q.scl;
  wire scl_high = pin_s2.scl & pin_q.scl;
  wire start_cond = scl_high & pin_q.sda & ~pin_s2.sda;
  wire stop_cond = scl_high & ~pin_q.sda & pin_s2.sda;
  wire rst_rise = pin_s2.rst & ~pin_q.rst;
  wire ready = settle == 2'h3;

  // byte decode; a busy device ignores its address
  wire [7:0] byte_in = {shreg, pin_s2.sda};
  wire id_valid = dev_id != `SMF_ID_NONE;
  wire dev_hit = ready & id_valid & (byte_in[7:4] == dev_id) & ~prog_busy;
  wire wr_ok = atr_sel | zone_ok(zone_rights.wr, addr);
  wire rd_ok = zone_ok(zone_rights.rd, addr);
  wire [7:0] atr_q = atr_reg[{addr[2:0], 3'b000} +: 8];
  wire [7:0] mem_q = atr_sel ? atr_q : (rd_ok ? mem[addr] : `SMF_UNREADABLE);
  wire in_dev = state == TW_DEV;
  wire in_addr = state == TW_ADDR;
  wire in_wdata = state == TW_WDATA;
  wire in_rdata = state == TW_RDATA;
  wire byte_end = scl_rise & (bitcnt == `SMF_LAST_BIT);
  wire byte_ack = (in_dev & dev_hit) | in_addr | (in_wdata & wr_ok);
  wire store_en = byte_end & in_wdata & wr_ok;
  wire page_clr = byte_end & in_addr;
  // the device's own ack after the device byte is no host answer
  wire host_slot = scl_rise & in_rdata & (bitcnt == `SMF_ACK_SLOT) & ~ack_ok;
  wire host_nack = host_slot & pin_s2.sda;

  // what the line shows after a clock fall
  wire drv_ack = (bitcnt == `SMF_ACK_SLOT) & ack_ok;
  wire drv_first = (bitcnt == 4'h0) & in_rdata & ~mem_q[7];
  wire drv_rest = (bitcnt != 4'h0) & (bitcnt != `SMF_ACK_SLOT) & in_rdata & ~rdata[7];
  wire next_low = drv_ack | drv_first | drv_rest;

  // two-wire bit engine: in on clock rise, out on clock fall
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state <= TW_IDLE;
      bitcnt <= 4'h0;
      shreg <= 7'h00;
      addr <= 8'h00;
      atr_sel <= 1'b0;
      ack_ok <= 1'b0;
      rdata <= 8'h00;
      twi_low <= 1'b0;
    end
    else if (start_cond)
    begin
      state <= TW_DEV;
      bitcnt <= 4'h0;
      ack_ok <= 1'b0;
      twi_low <= 1'b0;
    end
    else if (stop_cond)
    begin
      state <= TW_IDLE;
      twi_low <= 1'b0;
    end
    else if (scl_rise && state != TW_IDLE)
    begin
      bitcnt <= (bitcnt == `SMF_ACK_SLOT) ? 4'h0 : bitcnt + 4'h1;
      shreg <= byte_in[6:0];
      if (byte_end)
      begin
        ack_ok <= byte_ack;
        unique case (state)
          TW_DEV:
          begin
            atr_sel <= byte_in[`SMF_DEV_ATR_BIT];
            if (!dev_hit)
              state <= TW_IDLE;
            else if (byte_in[`SMF_DEV_RW_BIT])
              state <= TW_RDATA;
            else
              state <= TW_ADDR;
          end
          TW_ADDR:
          begin
            addr <= byte_in;
            state <= TW_WDATA;
          end
          TW_WDATA:
          begin
            addr[3:0] <= addr[3:0] + 4'h1;
            if (!wr_ok)
              state <= TW_IDLE;
          end
          TW_RDATA:
            state <= TW_RDATA;
        endcase
      end
      if (host_nack)
        state <= TW_IDLE;
      else if (host_slot)
        addr <= addr + 8'h01;
    end
    else if (scl_fall)
    begin
      twi_low <= (state != TW_IDLE) & next_low;
      if (bitcnt == 4'h0)
        rdata <= {mem_q[6:0], 1'b0};
      else
        rdata <= {rdata[6:0], 1'b0};
    end
  end

  // page buffer: one byte lane each, wrapping inside the page
  genvar i;
  generate
    for (i = 0; i < `SMF_PAGE_BYTES; i++)
    begin : g_page
      always_ff @(posedge clock)
      begin
        if (!reset_n)
        begin
          pg[i] <= 8'h00;
          pg_valid[i] <= 1'b0;
        end
        else if (page_clr)
          pg_valid[i] <= 1'b0;
        else if (store_en && addr[3:0] == 4'(i))
        begin
          pg[i] <= byte_in;
          pg_valid[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // page placement is taken from the address byte
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      pg_page <= 4'h0;
      pg_atr <= 1'b0;
    end
    else if (page_clr)
    begin
      pg_page <= byte_in[7:4];
      pg_atr <= atr_sel;
    end
  end

  // self-timed cycle after a stop; bytes land one per clock at its end
  wire prog_go = stop_cond & in_wdata & (|pg_valid);
  wire timer_done = prog_cnt == 20'(WR_CYCLES - 1);
  wire prog_put = prog_busy & timer_done & pg_valid[walk];

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      prog_busy <= 1'b0;
      prog_cnt <= 20'h00000;
      walk <= 4'h0;
    end
    else if (prog_go)
    begin
      prog_busy <= 1'b1;
      prog_cnt <= 20'h00000;
      walk <= 4'h0;
    end
    else if (prog_busy && !timer_done)
      prog_cnt <= prog_cnt + 20'h00001;
    else if (prog_busy)
    begin
      walk <= walk + 4'h1;
      prog_busy <= walk != 4'hf;
    end
  end

  // user memory has no reset, as a nonvolatile array would not
  always_ff @(posedge clock)
  begin
    if (prog_put && !pg_atr)
      mem[{pg_page, walk}] <= pg[walk];
  end

  // answer register, written through the same page path
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      atr_reg <= `SMF_ATR_RESET;
    else if (prog_put && pg_atr && !walk[3])
      atr_reg[{walk[2:0], 3'b000} +: 8] <= pg[walk];
  end

  // mode tracking and answer launch; a start condition means two-wire use
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      sync_mode <= 1'b0;
      atr_tgl <= 1'b0;
      atr_hold <= `SMF_ATR_RESET;
    end
    else
    begin
      if (start_cond)
        sync_mode <= 1'b1;
      else if (!pin_s2.rst)
        sync_mode <= 1'b0;
      if (rst_rise && ready && t0_en && !sync_mode)
      begin
        atr_hold <= atr_reg;
        atr_tgl <= ~atr_tgl;
      end
    end
  end

  // link side: carrier clock, counts elementary time units
  wire link_run_in = reset_n & pin_s2.rst;
  logic run_s1;
  logic run_s2;
  logic tg_s1;
  logic tg_s2;
  logic tg_q;
  smf_atr_t at_state;
  logic [`SMF_ETU_W-1:0] etu_cnt;
  logic [3:0] bit_idx;
  logic [2:0] byte_idx;
  logic [11:0] tx_sh;
  logic [63:0] atr_sh;

  // level and toggle crossings; atr_hold changes with the toggle and is stable before tg_s2 sees it
  always_ff @(posedge serial_clk)
  begin
    run_s1 <= link_run_in;
    run_s2 <= run_s1;
    tg_s1 <= atr_tgl;
    tg_s2 <= tg_s1;
    tg_q <= tg_s2;
  end

  wire etu_end = etu_cnt == `SMF_ETU_W'(`SMF_ETU_CLKS - 1);
  wire char_end = etu_end & (bit_idx == `SMF_CHAR_LAST);

  // answer sender; reset pad low aborts it mid-character
  always_ff @(posedge serial_clk)
  begin
    if (!run_s2)
    begin
      at_state <= AT_IDLE;
      etu_cnt <= '0;
      bit_idx <= 4'h0;
      byte_idx <= 3'h0;
      tx_sh <= 12'hfff;
      atr_sh <= 64'h0;
    end
    else
    begin
      unique case (at_state)
        AT_IDLE:
          if (tg_s2 != tg_q)
          begin
            at_state <= AT_SEND;
            atr_sh <= atr_hold;
            tx_sh <= mk_frame(atr_hold[7:0]);
            etu_cnt <= '0;
            bit_idx <= 4'h0;
            byte_idx <= 3'h0;
          end
        AT_SEND:
        begin
          etu_cnt <= etu_end ? '0 : etu_cnt + 1'b1;
          if (char_end && byte_idx == `SMF_ATR_LAST)
            at_state <= AT_IDLE;
          else if (char_end)
          begin
            byte_idx <= byte_idx + 3'h1;
            bit_idx <= 4'h0;
            atr_sh <= {8'h00, atr_sh[63:8]};
            tx_sh <= mk_frame(atr_sh[15:8]);
          end
          else if (etu_end)
          begin
            bit_idx <= bit_idx + 4'h1;
            tx_sh <= {1'b1, tx_sh[11:1]};
          end
        end
      endcase
    end
  end

  // open drain: the pad is only ever pulled low or let go
  assign sda_out = 1'b0;
  assign sda_oe = twi_low | ((at_state == AT_SEND) & ~tx_sh[0]);
  assign atr_active = at_state == AT_SEND;
endmodule

// [smf_front_end_test.sv]
// self-checking bench for the serial front end
`timescale 1ns/100ps
`include "smf_cfg.svh"
module smf_front_end_test;
  import smf_pkg::*;
  localparam int WR = 20;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic serial_clk;
  logic sda_in;
  logic sda_out;
  logic sda_oe;
  logic rst_pad = 1'b0;
  logic rst_pad_driven = 1'b0;
  logic [3:0] dev_id_strap = 4'h3;
  logic t0_strap = 1'b0;
  smf_rights_t zone_rights = 8'hbd;
  logic prog_busy;
  logic atr_active;
  int failures = 0;
  int n_checks = 0;
  always #2.5 clock = ~clock;
  smf_front_end #(.WR_CYCLES(WR)) u_smf_front_end (.clock, .reset_n, .serial_clk, .sda_in, .sda_out, .sda_oe,
    .rst_pad, .rst_pad_driven, .dev_id_strap, .t0_strap, .zone_rights, .prog_busy, .atr_active);
  smf_host u_smf_host (.clock, .sda_oe, .sda_out, .serial_clk, .sda_in);
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop;
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // four carrier pulses during reset, three rises as the line starts high: two to cross it, the rest to clear the link side
  task automatic do_reset(input logic t0);
    reset_n = 1'b0;
    t0_strap = t0;
    fork
      u_smf_host.carrier(4);
      u_smf_host.tick(16);
    join
    u_smf_host.tick(1);
    reset_n = 1'b1;
    u_smf_host.tick(8);
  endtask
  task automatic put(input logic [7:0] d, input logic want);
    logic [7:0] q;
    logic a;
    u_smf_host.xfer(d, 1'b1, q, a);
    check(8'(a), 8'(want));
  endtask
  task automatic get(input logic more, input logic [7:0] want);
    logic [7:0] q;
    logic a;
    u_smf_host.xfer(8'hff, !more, q, a);
    check(q, want);
  endtask
  task automatic await_busy(input logic v, input int n);
    for (int k = 0; k < n && prog_busy !== v; k++)
      u_smf_host.tick(1);
    check(8'(prog_busy), 8'(v));
  endtask
  // two-byte page write, then the self-timed cycle
  task automatic tw_write_page;
    u_smf_host.start_cond();
    put(8'h30, 1'b1);
    put(8'h05, 1'b1);
    put(8'ha5, 1'b1);
    put(8'h3c, 1'b1);
    u_smf_host.stop_cond();
    await_busy(1'b1, 20);
    await_busy(1'b0, WR + 40);
  endtask
  // address by write, repeated start, sequential read
  task automatic tw_read_back;
    u_smf_host.start_cond();
    put(8'h30, 1'b1);
    put(8'h05, 1'b1);
    u_smf_host.start_cond();
    put(8'h31, 1'b1);
    get(1'b1, 8'ha5);
    get(1'b0, 8'h3c);
    u_smf_host.stop_cond();
  endtask
  // foreign address, locked zone write, locked zone read
  task automatic tw_refusals;
    u_smf_host.start_cond();
    put(8'h70, 1'b0);
    u_smf_host.stop_cond();
    u_smf_host.start_cond();
    put(8'h30, 1'b1);
    put(8'h45, 1'b1);
    put(8'h99, 1'b0);
    u_smf_host.stop_cond();
    await_busy(1'b0, 10);
    u_smf_host.start_cond();
    put(8'h30, 1'b1);
    put(8'h85, 1'b1);
    u_smf_host.start_cond();
    put(8'h31, 1'b1);
    get(1'b0, 8'hff);
    u_smf_host.stop_cond();
    zone_rights = 8'h0d;
    u_smf_host.start_cond();
    put(8'h30, 1'b1);
    put(8'h05, 1'b1);
    u_smf_host.start_cond();
    put(8'h31, 1'b1);
    get(1'b0, 8'hff);
    u_smf_host.stop_cond();
    zone_rights = 8'hbd;
  endtask
  // unbonding the low pad reads as a release; first character then abort
  task automatic answer_unbonded;
    logic [9:0] b;
    logic [63:0] atr;
    atr = `SMF_ATR_RESET;
    rst_pad_driven = 1'b0;
    u_smf_host.rx_char(b);
    check(b[8:1], atr[7:0]);
    check(8'({b[9], b[0]}), 8'({^atr[7:0], 1'b0}));
    check(8'(sda_in), 8'h01);
    check(8'(atr_active), 8'h01);
    u_smf_host.tick(1);
    rst_pad_driven = 1'b1;
    u_smf_host.carrier(8);
    check(8'(atr_active), 8'h00);
  endtask
  // bonded pad: a rise opens an answer, low again cuts it in its start bit
  task automatic answer_bonded;
    u_smf_host.tick(1);
    rst_pad = 1'b1;
    for (int k = 0; k < 200 && sda_in; k++)
      u_smf_host.carrier(1);
    check(8'(sda_in), 8'h00);
    check(8'(atr_active), 8'h01);
    u_smf_host.tick(1);
    rst_pad = 1'b0;
    u_smf_host.carrier(8);
    check(8'(atr_active), 8'h00);
    check(8'(sda_in), 8'h01);
  endtask
  // with no address strapped the device answers no one
  task automatic tw_no_id;
    u_smf_host.start_cond();
    put(8'hf0, 1'b0);
    u_smf_host.stop_cond();
  endtask
  initial
  begin
    do_reset(1'b0);
    tw_write_page();
    tw_read_back();
    tw_refusals();
    rst_pad_driven = 1'b1;
    dev_id_strap = 4'hf;
    do_reset(1'b1);
    answer_unbonded();
    answer_bonded();
    tw_no_id();
    report_and_stop();
  end
  // tests need about 70k cycles
  initial
  begin
    repeat (95000) @(posedge clock);
    failures++;
    report_and_stop();
  end
endmodule
bind smf_front_end smf_monitor #(.WR_CYCLES(WR_CYCLES)) u_smf_monitor (.clock, .reset_n, .serial_clk, .sda_in,
  .sda_out, .sda_oe, .rst_pad, .rst_pad_driven, .dev_id_strap, .t0_strap, .zone_rights, .prog_busy, .atr_active);

// [smf_host.sv]
// host model: two-wire master, carrier source, answer receiver
`timescale 1ns/100ps
module smf_host
(
  input wire logic clock,
  input wire logic sda_oe,
  input wire logic sda_out,
  output logic serial_clk,
  output logic sda_in
);
  localparam int HALF = 40;
  logic drive_low = 1'b0;
  initial serial_clk = 1'b1;
  // open-drain wire with pull-up
  assign sda_in = ((sda_oe && !sda_out) || drive_low) ? 1'b0 : 1'b1;
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // data moves mid-low, read mid-high
  task automatic bit_io(input logic b, output logic seen);
    tick(HALF / 2);
    drive_low = !b;
    tick(HALF / 2);
    serial_clk = 1'b1;
    tick(HALF / 2);
    seen = sda_in;
    tick(HALF / 2);
    serial_clk = 1'b0;
  endtask
  // data falls with clock high
  task automatic start_cond;
    tick(HALF / 2);
    drive_low = 1'b0;
    tick(HALF / 2);
    serial_clk = 1'b1;
    tick(HALF / 2);
    drive_low = 1'b1;
    tick(HALF / 2);
    serial_clk = 1'b0;
  endtask
  task automatic stop_cond;
    tick(HALF / 2);
    drive_low = 1'b1;
    tick(HALF / 2);
    serial_clk = 1'b1;
    tick(HALF / 2);
    drive_low = 1'b0;
    tick(HALF / 2);
  endtask
  // one byte msb first plus the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ack_in, s);
    ack = !s;
  endtask
  // 64 ns carrier, phase drifts against the system clock
  task automatic carrier(input int n);
    repeat (n)
    begin
      serial_clk = 1'b1;
      #32;
      serial_clk = 1'b0;
      #32;
    end
  endtask
  // start, 8 data and parity, each sampled mid-bit
  task automatic rx_char(output logic [9:0] bits);
    for (int k = 0; k < 200 && sda_in; k++)
      carrier(1);
    carrier(186);
    for (int i = 0; i < 10; i++)
    begin
      bits[i] = sda_in;
      carrier(372);
    end
  endtask
endmodule

// [smf_monitor.sv]
// port checker for the serial front end
`timescale 1ns/100ps
module smf_monitor
#(
  parameter int WR_CYCLES = 20
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic serial_clk,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic rst_pad,
  input wire logic rst_pad_driven,
  input wire logic [3:0] dev_id_strap,
  input wire logic t0_strap,
  input wire smf_pkg::smf_rights_t zone_rights,
  input wire logic prog_busy,
  input wire logic atr_active
);
  import smf_pkg::*;
  localparam int ETU = 372;
  localparam int BUSY_MAX = WR_CYCLES + 24;
  logic rst_hi;
  logic tw;
  logic scl_q;
  logic sda_q;
  logic oe_l;
  logic armed;
  logic [3:0] stop_age;
  int busy_len;
  int run;
  // an unbonded pad counts as high
  assign rst_hi = rst_pad || !rst_pad_driven;
  // raw pin view; our own pull is no host start
  always_ff @(posedge clock)
  begin
    scl_q <= serial_clk;
    sda_q <= sda_in;
    tw <= reset_n && rst_hi && (tw || (scl_q && serial_clk && sda_q && !sda_in && !sda_oe));
    if (!reset_n)
      stop_age <= 4'hf;
    else if (scl_q && serial_clk && !sda_q && sda_in)
      stop_age <= 4'h0;
    else if (stop_age != 4'hf)
      stop_age <= stop_age + 4'h1;
    busy_len <= prog_busy ? busy_len + 1 : 0;
  end
  // carrier periods between line changes, armed only inside an answer
  always_ff @(posedge serial_clk)
  begin
    oe_l <= sda_oe;
    armed <= reset_n && atr_active && (armed || sda_oe != oe_l);
    run <= (sda_oe != oe_l) ? 1 : run + 1;
  end
  sequence s_answer_rise;
    $rose(atr_active);
  endsequence
  sequence s_start_pull;
    ##[0:80] sda_oe;
  endsequence
  chk_drive_low: assert property (@(posedge clock) disable iff (!reset_n) !sda_out)
    else $error("data pin driven high");
  chk_ack_fall: assert property (@(posedge clock) disable iff (!reset_n)
    tw && $rose(sda_oe) |-> !serial_clk) else $error("pull began with clock high");
  chk_busy_stop: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(prog_busy) |-> stop_age < 4'h8) else $error("programming without stop");
  chk_busy_length: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(prog_busy) |-> busy_len >= WR_CYCLES && busy_len <= BUSY_MAX) else $error("bad write time");
  chk_bit_time: assert property (@(posedge serial_clk) disable iff (!reset_n)
    armed && atr_active && sda_oe != oe_l |-> run % ETU == 0) else $error("answer bit length wrong");
  chk_answer_cause: assert property (@(posedge clock) disable iff (!reset_n)
    s_answer_rise |-> rst_hi && t0_strap && !tw) else $error("answer without cause");
  chk_answer_pull: assert property (@(posedge clock) disable iff (!reset_n)
    s_answer_rise |-> s_start_pull) else $error("answer without start bit");
  chk_quiet_tw: assert property (@(posedge clock) disable iff (!reset_n)
    tw |-> !atr_active) else $error("answer in two-wire use");
endmodule

// [smf_pkg.sv]
// types for the secure memory serial front end
package smf_pkg;
  typedef struct packed {
    logic t0_en;
    logic [3:0] dev_id;
    logic rst;
    logic sda;
    logic scl;
  } smf_pins_t;
  typedef struct packed {
    logic [3:0] rd;
    logic [3:0] wr;
  } smf_rights_t;
  typedef enum logic [4:0] {
    TW_IDLE = 5'b00001,
    TW_DEV = 5'b00010,
    TW_ADDR = 5'b00100,
    TW_WDATA = 5'b01000,
    TW_RDATA = 5'b10000
  } smf_twi_t;
  typedef enum logic [1:0] {
    AT_IDLE = 2'b01,
    AT_SEND = 2'b10
  } smf_atr_t;
endpackage
